// ### src/nvram_pkg.sv
package nvram_pkg;

	// instruction frame layout
	localparam int unsigned INSTR_BITS  = 8;
	localparam int unsigned ADDR_BITS   = 4;
	localparam int unsigned OPC_BITS    = 3;
	localparam int unsigned WORD_BITS   = 16;
	localparam int unsigned WORD_COUNT  = 16;
	localparam int unsigned CNT_BITS    = 5;
	// edge index (start bit is 1) on which the last opcode bit is taken
	localparam logic [4:0]  OPC_LAST_CNT = 5'h08;
	localparam logic [4:0]  START_CNT    = 5'h01;
	localparam logic [4:0]  CNT_MAX      = 5'h1F;

	// opcodes, I2 I1 I0
	localparam logic [2:0] OPC_LATCH_CLEAR = 3'h0;
	localparam logic [2:0] OPC_LATCH_SET   = 3'h4;
	localparam logic [2:0] OPC_WRITE       = 3'h3;
	localparam logic [2:0] OPC_NV_SAVE     = 3'h1;
	localparam logic [2:0] OPC_NV_RELOAD   = 3'h5;
	localparam logic [2:0] OPC_SLEEP       = 3'h2;
	// read is 11X: only the two upper opcode bits decide it
	localparam logic [1:0] OPC_READ_HI     = 2'h3;

	// timing
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned STORE_TIME_NS  = 10_000_000;
	localparam int unsigned RECALL_TIME_NS = 2500;
	// longest time: round down
	localparam int unsigned STORE_CYCLES   = STORE_TIME_NS / CLK_PERIOD_NS;
	// least time: round up
	localparam int unsigned RECALL_CYCLES  = (RECALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// reset values
	localparam logic RST_WRITE_LATCH  = 1'b0;
	localparam logic RST_RECALL_LATCH = 1'b0;
	localparam logic RST_SLEEP        = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_STORE  = 2'h1,
		ST_RECALL = 2'h2
	} nv_state_e;

endpackage

// ### src/serial_nvram_command_logic.sv
`timescale 1ns/100ps
// Overview of operation
// - power-up clears recall latch; clear latch blocks store
// - any recall sets the recall latch
// - power-up or clear command clears write latch
// - set command sets the write latch
// - finished store clears the write latch
// - store only with both latches set
// - read shifts addressed word out after opcode
// - write data follows opcode; needs write latch
// - store copies whole SRAM into EEPROM
// - store during read tri-states data out
// - store blocks every other operation
// - recall reloads SRAM, tri-states, blocks others
// - sleep disables SRAM until a recall
// - chip select low means idle standby
// - first high sample after select is start
// - data in sampled on rising shift clock
// - first data bit on falling eighth clock
// - write data committed on rising shift clock
// - clock and data high at select count
// - eight-bit frame: start, address, opcode
// - read, write, store, recall opcodes
// - latch clear, latch set, sleep opcodes
module serial_nvram_command_logic #(
	parameter int unsigned WORD_BITS     = nvram_pkg::WORD_BITS,
	parameter int unsigned WORD_COUNT    = nvram_pkg::WORD_COUNT,
	parameter int unsigned STORE_CYCLES  = nvram_pkg::STORE_CYCLES,
	parameter int unsigned RECALL_CYCLES = nvram_pkg::RECALL_CYCLES
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	input  wire logic serial_shift_clock_i,
	input  wire logic chip_select_i,
	input  wire logic serial_data_in_i,
	input  wire logic store_n_i,
	input  wire logic recall_n_i,
	output logic      serial_data_out_o,
	output logic      serial_data_out_oe_o,
	output logic      nv_busy_o,
	output logic      write_latch_o,
	output logic      recall_latch_o,
	output logic      sleep_o
);

	localparam int unsigned AW = nvram_pkg::ADDR_BITS;
	localparam int unsigned CW = nvram_pkg::CNT_BITS;
	localparam int unsigned TW = $clog2(STORE_CYCLES + 1);
	localparam logic [CW-1:0] WR_LAST_CNT = CW'(nvram_pkg::OPC_LAST_CNT + WORD_BITS);

	initial begin
		if (WORD_COUNT > (1 << AW) || WORD_COUNT < 1)
			$error("WORD_COUNT must fit the address field");
		if (WORD_BITS < 1 || nvram_pkg::OPC_LAST_CNT + WORD_BITS >= nvram_pkg::CNT_MAX)
			$error("WORD_BITS out of range for the bit counter");
		if (RECALL_CYCLES < 1 || STORE_CYCLES < RECALL_CYCLES)
			$error("store and recall counts must be at least one cycle");
	end

	////////////////////////////////////////////////////////////////////////////
	// storage: SRAM lives on the link clock, EEPROM on the core clock

	logic [WORD_BITS-1:0] sram_mem   [WORD_COUNT];
	logic [WORD_BITS-1:0] eeprom_mem [WORD_COUNT];

	////////////////////////////////////////////////////////////////////////////
	// core domain: pin and command synchronisers

	logic [2:0] store_pin_q;
	logic [2:0] recall_pin_q;
	logic [2:0] cmd_sync_q;
	logic       cmd_tgl_q;
	logic [2:0] cmd_op_q;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			store_pin_q  <= 3'h7;
			recall_pin_q <= 3'h7;
			cmd_sync_q   <= 3'h0;
		end else begin
			store_pin_q  <= {store_pin_q[1:0], store_n_i};
			recall_pin_q <= {recall_pin_q[1:0], recall_n_i};
			cmd_sync_q   <= {cmd_sync_q[1:0], cmd_tgl_q};
		end
	end

	logic cmd_event;
	logic store_req;
	logic recall_req;

	// cmd_op_q is stable for many core cycles once the toggle is seen
	assign cmd_event  = cmd_sync_q[2] ^ cmd_sync_q[1];
	assign store_req  = (cmd_event && cmd_op_q == nvram_pkg::OPC_NV_SAVE)
		|| (store_pin_q[2] && !store_pin_q[1]);
	assign recall_req = (cmd_event && cmd_op_q == nvram_pkg::OPC_NV_RELOAD)
		|| (recall_pin_q[2] && !recall_pin_q[1]);

	////////////////////////////////////////////////////////////////////////////
	// core domain: store / recall sequencer and latches

	nvram_pkg::nv_state_e state_q;
	logic [TW-1:0]        timer_q;
	logic                 write_latch_q;
	logic                 recall_latch_q;
	logic                 sleep_q;
	logic                 busy_q;
	logic                 rcl_tgl_q;
	logic                 store_done;

	assign store_done = state_q == nvram_pkg::ST_STORE && timer_q == '0;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q        <= nvram_pkg::ST_IDLE;
			timer_q        <= '0;
			write_latch_q  <= nvram_pkg::RST_WRITE_LATCH;
			recall_latch_q <= nvram_pkg::RST_RECALL_LATCH;
			sleep_q        <= nvram_pkg::RST_SLEEP;
			busy_q         <= 1'b0;
			rcl_tgl_q      <= 1'b0;
		end else begin
			case (state_q)
				nvram_pkg::ST_IDLE: begin
					// recall wins if both arrive together
					if (recall_req) begin
						state_q <= nvram_pkg::ST_RECALL;
						timer_q <= TW'(RECALL_CYCLES - 1);
						busy_q  <= 1'b1;
					end else if (store_req && write_latch_q && recall_latch_q) begin
						state_q <= nvram_pkg::ST_STORE;
						timer_q <= TW'(STORE_CYCLES - 1);
						busy_q  <= 1'b1;
					end else if (cmd_event) begin
						// refused stores fall through untouched
						if (cmd_op_q == nvram_pkg::OPC_LATCH_CLEAR)
							write_latch_q <= 1'b0;
						if (cmd_op_q == nvram_pkg::OPC_LATCH_SET)
							write_latch_q <= 1'b1;
						if (cmd_op_q == nvram_pkg::OPC_SLEEP)
							sleep_q <= 1'b1;
					end
				end
				nvram_pkg::ST_STORE: begin
					// requests arriving now are dropped
					if (timer_q == '0) begin
						state_q       <= nvram_pkg::ST_IDLE;
						busy_q        <= 1'b0;
						write_latch_q <= 1'b0;
					end else begin
						timer_q <= timer_q - TW'(1);
					end
				end
				nvram_pkg::ST_RECALL: begin
					if (timer_q == '0) begin
						state_q        <= nvram_pkg::ST_IDLE;
						busy_q         <= 1'b0;
						rcl_tgl_q      <= ~rcl_tgl_q;
						recall_latch_q <= 1'b1;
						sleep_q        <= 1'b0;
					end else begin
						timer_q <= timer_q - TW'(1);
					end
				end
				default: begin
					state_q <= nvram_pkg::ST_IDLE;
					busy_q  <= 1'b0;
				end
			endcase
		end
	end

	// the link side is frozen by busy, so the SRAM array is quasi-static here
	always_ff @(posedge ref_clk_i) begin
		if (store_done) begin
			for (int i = 0; i < WORD_COUNT; i++)
				eeprom_mem[i] <= sram_mem[i];
		end
	end

	assign nv_busy_o      = busy_q;
	assign write_latch_o  = write_latch_q;
	assign recall_latch_o = recall_latch_q;
	assign sleep_o        = sleep_q;

	////////////////////////////////////////////////////////////////////////////
	// link domain: level synchronisers and start capture

	logic [1:0] busy_sync_q;
	logic [1:0] wen_sync_q;
	logic [1:0] sleep_sync_q;
	logic [1:0] rcl_sync_q;
	logic       rcl_seen_q;
	logic       pre_start_q;

	always_ff @(posedge serial_shift_clock_i or posedge rst_i) begin
		if (rst_i) begin
			busy_sync_q  <= 2'h0;
			wen_sync_q   <= 2'h0;
			sleep_sync_q <= 2'h0;
			rcl_sync_q   <= 2'h0;
		end else begin
			busy_sync_q  <= {busy_sync_q[0], busy_q};
			wen_sync_q   <= {wen_sync_q[0], write_latch_q};
			sleep_sync_q <= {sleep_sync_q[0], sleep_q};
			rcl_sync_q   <= {rcl_sync_q[0], rcl_tgl_q};
		end
	end

	// clock and data already high as select rises: that is clock one
	always_ff @(posedge chip_select_i or posedge rst_i) begin
		if (rst_i)
			pre_start_q <= 1'b0;
		else
			pre_start_q <= serial_shift_clock_i & serial_data_in_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// link domain: instruction frame

	logic                 link_rst;
	logic                 started_q;
	logic                 aborted_q;
	logic [CW-1:0]        cnt_q;
	logic [AW+1:0]        instr_q;
	logic [AW-1:0]        addr_q;
	logic                 rd_q;
	logic                 wr_q;
	logic                 phase_q;
	logic [WORD_BITS-1:0] shift_q;
	logic [WORD_BITS-1:0] wdata_q;
	logic                 started_e;
	logic [CW-1:0]        cnt_e;
	logic                 frame_go;
	logic                 at_opcode;
	logic [2:0]           opcode;
	logic                 wr_commit;
	logic                 rcl_pending;

	// select low holds the frame logic in reset: that is standby
	assign link_rst    = rst_i | ~chip_select_i;
	assign started_e   = started_q | pre_start_q;
	// a start taken at the select rise makes the next rising edge the second
	assign cnt_e       = started_q ? cnt_q : nvram_pkg::START_CNT + CW'(1);
	assign frame_go    = started_e & ~aborted_q & ~busy_sync_q[1];
	assign at_opcode   = frame_go && cnt_e == nvram_pkg::OPC_LAST_CNT;
	assign opcode      = {instr_q[1:0], serial_data_in_i};
	assign rcl_pending = rcl_sync_q[1] ^ rcl_seen_q;
	// latch must already be set; otherwise the word is dropped
	assign wr_commit   = frame_go && wr_q && cnt_e == WR_LAST_CNT
		&& wen_sync_q[1] && !sleep_sync_q[1];

	always_ff @(posedge serial_shift_clock_i or posedge link_rst) begin
		if (link_rst) begin
			started_q <= 1'b0;
			aborted_q <= 1'b0;
			cnt_q     <= '0;
			instr_q   <= '0;
			addr_q    <= '0;
			rd_q      <= 1'b0;
			wr_q      <= 1'b0;
			phase_q   <= 1'b0;
			shift_q   <= '0;
			wdata_q   <= '0;
		end else if (started_e && busy_sync_q[1]) begin
			aborted_q <= 1'b1;
		end else if (!started_e) begin
			if (serial_data_in_i) begin
				started_q <= 1'b1;
				cnt_q     <= nvram_pkg::START_CNT + CW'(1);
			end
		end else if (!aborted_q) begin
			started_q <= 1'b1;
			if (cnt_e != nvram_pkg::CNT_MAX)
				cnt_q <= cnt_e + CW'(1);
			if (cnt_e < nvram_pkg::OPC_LAST_CNT)
				instr_q <= {instr_q[AW:0], serial_data_in_i};
			if (at_opcode) begin
				addr_q <= instr_q[AW+1:2];
				if (opcode[2:1] == nvram_pkg::OPC_READ_HI && !sleep_sync_q[1]) begin
					rd_q    <= 1'b1;
					shift_q <= rcl_pending ? eeprom_mem[instr_q[AW+1:2]]
						: sram_mem[instr_q[AW+1:2]];
				end
				if (opcode == nvram_pkg::OPC_WRITE)
					wr_q <= 1'b1;
			end else if (rd_q) begin
				phase_q <= 1'b1;
				shift_q <= {shift_q[WORD_BITS-2:0], 1'b0};
			end else if (wr_q) begin
				wdata_q <= {wdata_q[WORD_BITS-2:0], serial_data_in_i};
			end
		end
	end

	// non-data instructions are handed to the core by a toggle
	always_ff @(posedge serial_shift_clock_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_tgl_q <= 1'b0;
			cmd_op_q  <= nvram_pkg::OPC_LATCH_CLEAR;
		end else if (at_opcode && opcode[2:1] != nvram_pkg::OPC_READ_HI
			&& opcode != nvram_pkg::OPC_WRITE) begin
			cmd_tgl_q <= ~cmd_tgl_q;
			cmd_op_q  <= opcode;
		end
	end

	// a finished recall is applied at the next link edge; until then reads see EEPROM
	always_ff @(posedge serial_shift_clock_i or posedge rst_i) begin
		if (rst_i)
			rcl_seen_q <= 1'b0;
		else if (rcl_pending)
			rcl_seen_q <= rcl_sync_q[1];
	end

	always_ff @(posedge serial_shift_clock_i) begin
		if (rcl_pending) begin
			for (int i = 0; i < WORD_COUNT; i++)
				sram_mem[i] <= eeprom_mem[i];
		end else if (wr_commit) begin
			sram_mem[addr_q] <= {wdata_q[WORD_BITS-2:0], serial_data_in_i};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link domain: data out, first bit on the falling edge

	logic first_q;
	logic drive_q;

	always_ff @(negedge serial_shift_clock_i or posedge link_rst) begin
		if (link_rst) begin
			first_q <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			if (rd_q && !phase_q)
				first_q <= shift_q[WORD_BITS-1];
			drive_q <= rd_q & ~aborted_q;
		end
	end

	// a mux of two flops: the first bit and the rest launch on opposite edges
	assign serial_data_out_o    = phase_q ? shift_q[WORD_BITS-1] : first_q;
	assign serial_data_out_oe_o = drive_q & ~aborted_q;

endmodule

// ### dv/nvram_chk.sv
`timescale 1ns/100ps
module nvram_chk #(
	parameter int unsigned STORE_CYCLES  = 20,
	parameter int unsigned RECALL_CYCLES = 5
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic serial_shift_clock_i,
	input wire logic chip_select_i,
	input wire logic serial_data_out_oe_o,
	input wire logic nv_busy_o,
	input wire logic write_latch_o,
	input wire logic recall_latch_o,
	input wire logic sleep_o
);
	logic [31:0] busy_cnt_q;

	// run length of the current transfer tells a store from a recall
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_cnt_q <= '0;
		end else if (nv_busy_o) begin
			busy_cnt_q <= busy_cnt_q + 32'h1;
		end else begin
			busy_cnt_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_busy_len: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) $fell(nv_busy_o)
		|-> busy_cnt_q == STORE_CYCLES || busy_cnt_q == RECALL_CYCLES)
		else $error("transfer length wrong");
	a_store_clears_wl: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		$fell(nv_busy_o) && busy_cnt_q == STORE_CYCLES |=> !write_latch_o)
		else $error("write latch kept after store");
	a_store_needs_rl: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		$fell(nv_busy_o) && busy_cnt_q == STORE_CYCLES |-> recall_latch_o)
		else $error("store without recall latch");
	a_rl_sticky: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) recall_latch_o |=> recall_latch_o)
		else $error("recall latch dropped");
	a_rl_from_recall: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(recall_latch_o) |-> $past(nv_busy_o) || $past(nv_busy_o, 2))
		else $error("recall latch set without recall");
	a_wl_set_idle: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(write_latch_o) |-> !nv_busy_o && !$past(nv_busy_o))
		else $error("write latch set while busy");
	a_sleep_exit: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) $fell(sleep_o) |-> recall_latch_o)
		else $error("sleep left without recall");
	a_no_oe_sleep: assert property (
		@(posedge ref_clk_i) disable iff (rst_i) $rose(serial_data_out_oe_o) |-> !sleep_o)
		else $error("output driven in sleep");
	a_oe_cs: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		!chip_select_i && !$past(chip_select_i) |-> !serial_data_out_oe_o)
		else $error("output driven while deselected");
	a_oe_busy: assert property (
		@(posedge serial_shift_clock_i) disable iff (rst_i) nv_busy_o && $past(nv_busy_o)
		&& $past(nv_busy_o, 2) && $past(nv_busy_o, 3) |-> !serial_data_out_oe_o)
		else $error("output driven during transfer");
endmodule

bind serial_nvram_command_logic nvram_chk #(
	.STORE_CYCLES (STORE_CYCLES),
	.RECALL_CYCLES(RECALL_CYCLES)
) chk (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.serial_shift_clock_i(serial_shift_clock_i),
	.chip_select_i(chip_select_i),
	.serial_data_out_oe_o(serial_data_out_oe_o),
	.nv_busy_o(nv_busy_o),
	.write_latch_o(write_latch_o),
	.recall_latch_o(recall_latch_o),
	.sleep_o(sleep_o)
);

// ### dv/nvram_host.sv
`timescale 1ns/100ps
// shift clock runs only while the host has bits to move
module nvram_host (
	output logic      sck_o,
	output logic      cs_o,
	output logic      sdi_o,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i
);
	logic oe_last;
	logic smp;

	initial begin
		sck_o   = 1'b0;
		cs_o    = 1'b0;
		sdi_o   = 1'b1;
		oe_last = 1'b0;
	end
	// one 6 ns period; device output is taken just before the rise
	task automatic bit_out(input logic b);
		sdi_o = b;
		#3;
		smp     = sdo_i;
		oe_last = sdo_oe_i;
		sck_o   = 1'b1;
		#3;
		sck_o = 1'b0;
	endtask
	task automatic idle_clk();
		repeat (3) bit_out(1'b1);
	endtask
	task automatic frame(input logic [7:0] ins, input int nd, input logic [15:0] wd,
			output logic [15:0] rd);
		#100;
		cs_o = 1'b1;
		#1.3;
		for (int i = 7; i >= 0; i--) bit_out(ins[i]);
		for (int i = 15; i >= 16 - nd; i--) begin
			bit_out(wd[i]);
			rd[i] = smp;
		end
		#3;
		cs_o  = 1'b0;
		sdi_o = 1'b1;
	endtask
endmodule

// ### dv/serial_nvram_command_logic_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
	$display("BAD %0t mismatch", $time); end end
module serial_nvram_command_logic_test;
	logic        ref_clk_i;
	logic        rst_i;
	logic        store_n_i;
	logic        recall_n_i;
	logic        sck, cs, sdi, sdo, oe, busy, wl, rl, slp;
	logic [15:0] rd_q;
	int          err_count;
	int          n_checks;

	nvram_host host (.sck_o(sck), .cs_o(cs), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(oe));
	serial_nvram_command_logic #(.STORE_CYCLES(20), .RECALL_CYCLES(5)) dut (
		.ref_clk_i           (ref_clk_i),
		.rst_i               (rst_i),
		.serial_shift_clock_i(sck),
		.chip_select_i       (cs),
		.serial_data_in_i    (sdi),
		.store_n_i           (store_n_i),
		.recall_n_i          (recall_n_i),
		.serial_data_out_o   (sdo),
		.serial_data_out_oe_o(oe),
		.nv_busy_o           (busy),
		.write_latch_o       (wl),
		.recall_latch_o      (rl),
		.sleep_o             (slp)
	);
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic close_out();
		if (err_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmd(input logic [2:0] op);
		host.frame({1'b1, 4'h0, op}, 0, 16'h0, rd_q);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		host.frame({1'b1, a, nvram_pkg::OPC_WRITE}, 16, d, rd_q);
	endtask
	task automatic rd(input logic [3:0] a);
		host.frame({1'b1, a, nvram_pkg::OPC_READ_HI, 1'b0}, 16, 16'hFFFF, rd_q);
	endtask
	task automatic pin(input logic rec);
		@(negedge ref_clk_i);
		if (rec) recall_n_i = 1'b0;
		else store_n_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		recall_n_i = 1'b1;
		store_n_i  = 1'b1;
	endtask
	// link edges afterwards let the link side see the idle core again
	task automatic run_nv(input logic exp);
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 12) begin
			@(negedge ref_clk_i);
			n++;
		end
		`CHK(busy, exp)
		while (busy !== 1'b0 && n < 60) begin
			@(negedge ref_clk_i);
			n++;
		end
		host.idle_clk();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_protect();
		`CHK(wl, nvram_pkg::RST_WRITE_LATCH)
		`CHK(rl, nvram_pkg::RST_RECALL_LATCH)
		pin(1'b0);
		run_nv(1'b0);
		cmd(nvram_pkg::OPC_LATCH_SET);
		cmd(nvram_pkg::OPC_NV_SAVE);
		run_nv(1'b0);
		`CHK(wl, 1'b1)
	endtask
	task automatic t_data();
		cmd(nvram_pkg::OPC_NV_RELOAD);
		run_nv(1'b1);
		`CHK(rl, 1'b1)
		wr(4'h3, 16'hA5A5);
		rd(4'h3);
		`CHK(rd_q, 16'hA5A5)
		cmd(nvram_pkg::OPC_NV_SAVE);
		run_nv(1'b1);
		`CHK(wl, 1'b0)
		pin(1'b0);
		run_nv(1'b0);
		wr(4'h3, 16'h1234);
		rd(4'h3);
		`CHK(rd_q, 16'hA5A5)
	endtask
	task automatic t_recall();
		cmd(nvram_pkg::OPC_LATCH_SET);
		wr(4'h3, 16'h1234);
		rd(4'h3);
		`CHK(rd_q, 16'h1234)
		cmd(nvram_pkg::OPC_LATCH_CLEAR);
		rd(4'h3);
		`CHK(wl, 1'b0)
		pin(1'b1);
		run_nv(1'b1);
		rd(4'h3);
		`CHK(rd_q, 16'hA5A5)
	endtask
	task automatic t_sleep();
		cmd(nvram_pkg::OPC_SLEEP);
		rd(4'h3);
		`CHK(slp, 1'b1)
		`CHK(host.oe_last, 1'b0)
		cmd(nvram_pkg::OPC_NV_RELOAD);
		run_nv(1'b1);
		`CHK(slp, 1'b0)
	endtask
	// store pin pulled while a read is shifting out
	task automatic t_abort();
		cmd(nvram_pkg::OPC_LATCH_SET);
		fork
			rd(4'h3);
			begin
				#160;
				pin(1'b0);
			end
		join
		`CHK(host.oe_last, 1'b0)
		run_nv(1'b1);
		`CHK(wl, 1'b0)
	endtask
	initial begin
		err_count  = 0;
		n_checks   = 0;
		rst_i      = 1'b1;
		store_n_i  = 1'b1;
		recall_n_i = 1'b1;
		host.idle_clk();
		repeat (2) @(negedge ref_clk_i);
		rst_i = 1'b0;
		host.idle_clk();
		t_protect();
		t_data();
		t_recall();
		t_sleep();
		t_abort();
		close_out();
	end
	initial begin
		#50000;
		err_count++;
		close_out();
	end
endmodule
